// File: src/atc_pkg.sv
// package of the 8-bit async timer/counter: register map, fields, resets, modes
// assumes one 200 MHz clock and a plain address/strobe register port
package atc_pkg;
    // register indices; byte address is the index itself on this port
    localparam logic [2:0] ADDR_CTRL_A = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B = 3'h1;
    localparam logic [2:0] ADDR_COUNT = 3'h2;
    localparam logic [2:0] ADDR_COMPARE = 3'h3;
    localparam logic [2:0] ADDR_ASYNC = 3'h4;
    localparam logic [2:0] ADDR_MASK = 3'h5;
    localparam logic [2:0] ADDR_FLAGS = 3'h6;
    // control A fields
    localparam int COM_LSB = 6;
    localparam int WGM_LSB = 0;
    // control B fields
    localparam int FORCE_BIT = 7;
    localparam int CS_LSB = 0;
    // async status fields
    localparam int EXTERNAL_CLOCK_ENABLE_BIT = 6;
    localparam int ASEL_BIT = 5;
    localparam int CNT_UB_BIT = 4;
    localparam int OCR_UB_BIT = 3;
    localparam int CTLA_UB_BIT = 1;
    localparam int CTLB_UB_BIT = 0;
    // mask and flag fields
    localparam int CMP_BIT = 1;
    localparam int OVF_BIT = 0;
    // reset values
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [9:0] RST_PRESC = 10'h000;
    // counter limits
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;

    typedef enum logic [1:0] {
        WGM_NORMAL = 2'b00,
        WGM_PHASE = 2'b01,
        WGM_CTC = 2'b10,
        WGM_FAST = 2'b11
    } atc_wgm_e;

    typedef enum logic [1:0] {
        COM_OFF = 2'b00,
        COM_TOGGLE = 2'b01,
        COM_CLEAR = 2'b10,
        COM_SET = 2'b11
    } atc_com_e;

    // one register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wrData;
        logic wrStb;
        logic rdStb;
    } atc_req_s;
endpackage

// File: src/atc_timer.sv
// 8-bit timer/counter with one compare channel and optional async timer clock
// assumes the crystal pin is asynchronous, everything else is on clk
`timescale 1ns/10ps

// What this block does
// [R1] force strobe in non-PWM mode makes a compare action on the pin, at once on clk, at the next crystal edge when async
// [R2] forced compare sets no flag and never clears the counter
// [R3] force strobe reads as zero and stores nothing
// [R4] software writes force as zero while a PWM mode runs
// [R5] clock field: stop, undivided, then taps /8 /32 /64 /128 /256 /1024
// [R6] counter is read/write; a write blocks the match on the next count
// [R7] compare register matched with counter on every count, driving flag and pin
// [R8] external clock enable takes the crystal pin as clock; oscillator runs only at zero
// [R9] software sets external clock enable before choosing async clocking
// [R10] async select zero runs from clk, one from crystal or external clock
// [R11] changing async select leaves counter, compare and control A undefined
// [R12] async select takes a written one only with RC or watchdog system clock at the write, else zero
// [R13] async writes set per-register busy flag until moved into timer domain
// [R14] software never writes a register while its busy flag is set
// [R15] counter reads live; compare and controls read their temporary copies
// [R16] reserved bits read as zero
// [R17] compare request when compare enable, global enable and flag are set
// [R18] overflow request when overflow enable, global enable and flag are set
// [R19] compare flag sets on match, clears by vector or writing one
// [R20] overflow flag sets at overflow or PWM bottom turn, clears by vector or one
// [R21] modes normal, phase PWM, CTC, fast PWM; top 0xFF except CTC uses compare
// [R22] pending temporary values move on the next async timer edge, clearing busy
module atc_timer (
    input wire logic clk,
    input wire logic arst_n,
    input wire atc_pkg::atc_req_s busReq,
    output logic [7:0] rdData,
    input wire logic crystalInputPin,
    input wire logic sysClkFromRc,
    input wire logic globalIrqEnable,
    input wire logic compareVectorAck,
    input wire logic overflowVectorAck,
    output logic compareIrqReq,
    output logic overflowIrqReq,
    output logic compareOutputPin,
    output logic crystalOscEnable,
    output logic externalClockBufEnable
);
    logic rstMeta_q, rstN;
    logic xtalMeta_q, xtalSync_q, xtalLast_q;
    logic asyncSel_q, extClk_q;
    logic [7:0] ctrlATmp_q, ctrlBTmp_q, ocrTmp_q, cntTmp_q;
    logic [7:0] ctrlA_q, ctrlB_q, ocr_q, cnt_q;
    logic cntUb_q, ocrUb_q, ctlAUb_q, ctlBUb_q;
    logic forcePend_q, forceEv;
    logic [1:0] mask_q, flags_q;
    logic [9:0] presc_q;
    logic dirDown_q, blockMatch_q, pin_q;
    logic cmpIrq_q, ovfIrq_q, oscEn_q, extBuf_q;
    logic [7:0] rdData_q;
    logic xtalEdge, srcTick, cntTick, match, ovfEv, bottomEv;
    logic wrCtlA, wrCtlB, wrCnt, wrOcr, wrAsync, wrMask, wrFlags;
    logic [7:0] top;
    logic [1:0] wgm, com;
    logic isPwm;

    // reset release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN <= rstMeta_q;
        end
    end

    // crystal pin synchroniser and rising edge detect
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            xtalMeta_q <= 1'b0;
            xtalSync_q <= 1'b0;
            xtalLast_q <= 1'b0;
        end else begin
            xtalMeta_q <= crystalInputPin;
            xtalSync_q <= xtalMeta_q;
            xtalLast_q <= xtalSync_q;
        end
    end

    // write decode
    always_comb begin
        wrCtlA = 1'b0;
        wrCtlB = 1'b0;
        wrCnt = 1'b0;
        wrOcr = 1'b0;
        wrAsync = 1'b0;
        wrMask = 1'b0;
        wrFlags = 1'b0;
        if (busReq.wrStb) begin
            if (busReq.addr == atc_pkg::ADDR_CTRL_A) begin
                wrCtlA = 1'b1;
            end else if (busReq.addr == atc_pkg::ADDR_CTRL_B) begin
                wrCtlB = 1'b1;
            end else if (busReq.addr == atc_pkg::ADDR_COUNT) begin
                wrCnt = 1'b1;
            end else if (busReq.addr == atc_pkg::ADDR_COMPARE) begin
                wrOcr = 1'b1;
            end else if (busReq.addr == atc_pkg::ADDR_ASYNC) begin
                wrAsync = 1'b1;
            end else if (busReq.addr == atc_pkg::ADDR_MASK) begin
                wrMask = 1'b1;
            end else if (busReq.addr == atc_pkg::ADDR_FLAGS) begin
                wrFlags = 1'b1;
            end
        end
    end

    // timer source: every clk, or each rising crystal edge in async mode
    assign xtalEdge = xtalSync_q & ~xtalLast_q & asyncSel_q; // [R10] [R8]
    assign srcTick = asyncSel_q ? xtalEdge : 1'b1; // [R10]
    assign wgm = ctrlA_q[atc_pkg::WGM_LSB +: 2];
    assign com = ctrlA_q[atc_pkg::COM_LSB +: 2];
    assign isPwm = (wgm == atc_pkg::WGM_PHASE) || (wgm == atc_pkg::WGM_FAST);
    assign top = (wgm == atc_pkg::WGM_CTC) ? ocr_q : atc_pkg::CNT_MAX; // [R21]

    // async status: clock selects and crystal control
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            asyncSel_q <= 1'b0;
            extClk_q <= 1'b0;
        end else if (wrAsync) begin
            extClk_q <= busReq.wrData[atc_pkg::EXTERNAL_CLOCK_ENABLE_BIT];
            // hardware refuses async unless the system clock allows it;
            // a switch leaves counter, compare and control A stale, not reloaded
            asyncSel_q <= busReq.wrData[atc_pkg::ASEL_BIT] & sysClkFromRc; // [R12] [R11]
        end
    end

    // temporary copies, always written by software
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrlATmp_q <= atc_pkg::RST_CTRL_A;
            ctrlBTmp_q <= atc_pkg::RST_CTRL_B;
            ocrTmp_q <= atc_pkg::RST_COMPARE;
            cntTmp_q <= atc_pkg::RST_COUNT;
        end else begin
            if (wrCtlA) begin
                ctrlATmp_q <= busReq.wrData;
            end
            if (wrCtlB) begin
                ctrlBTmp_q <= busReq.wrData;
            end
            if (wrOcr) begin
                ocrTmp_q <= busReq.wrData;
            end
            if (wrCnt) begin
                cntTmp_q <= busReq.wrData;
            end
        end
    end

    // busy flags: set by async write, cleared on the transfer edge
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cntUb_q <= 1'b0;
            ocrUb_q <= 1'b0;
            ctlAUb_q <= 1'b0;
            ctlBUb_q <= 1'b0;
        end else if (!asyncSel_q) begin
            cntUb_q <= 1'b0;
            ocrUb_q <= 1'b0;
            ctlAUb_q <= 1'b0;
            ctlBUb_q <= 1'b0;
        end else begin
            // a write in the edge cycle keeps its flag set
            cntUb_q <= wrCnt | (cntUb_q & ~xtalEdge); // [R13] [R22]
            ocrUb_q <= wrOcr | (ocrUb_q & ~xtalEdge); // [R13] [R22]
            ctlAUb_q <= wrCtlA | (ctlAUb_q & ~xtalEdge); // [R13] [R22]
            ctlBUb_q <= wrCtlB | (ctlBUb_q & ~xtalEdge); // [R13] [R22]
        end
    end

    // timer-domain copies: immediate in sync mode, on edge when async
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrlA_q <= atc_pkg::RST_CTRL_A;
            ctrlB_q <= atc_pkg::RST_CTRL_B;
            ocr_q <= atc_pkg::RST_COMPARE;
        end else if (!asyncSel_q) begin
            if (wrCtlA) begin
                ctrlA_q <= busReq.wrData;
            end
            if (wrCtlB) begin
                ctrlB_q <= busReq.wrData;
            end
            if (wrOcr) begin
                ocr_q <= busReq.wrData;
            end
        end else if (xtalEdge) begin
            if (ctlAUb_q) begin
                ctrlA_q <= ctrlATmp_q; // [R22]
            end
            if (ctlBUb_q) begin
                ctrlB_q <= ctrlBTmp_q; // [R22]
            end
            if (ocrUb_q) begin
                ocr_q <= ocrTmp_q; // [R22]
            end
        end
    end

    // force strobe: pending until it reaches the timer domain
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            forcePend_q <= 1'b0;
        end else if (!asyncSel_q) begin
            forcePend_q <= 1'b0;
        end else if (wrCtlB) begin
            forcePend_q <= busReq.wrData[atc_pkg::FORCE_BIT];
        end else if (xtalEdge) begin
            forcePend_q <= 1'b0;
        end
    end
    assign forceEv = ~isPwm & (asyncSel_q ? (xtalEdge & forcePend_q & ctlBUb_q)
                     : (wrCtlB & busReq.wrData[atc_pkg::FORCE_BIT])); // [R1]

    // prescaler advances on every source tick
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            presc_q <= atc_pkg::RST_PRESC;
        end else if (srcTick) begin
            presc_q <= presc_q + 10'h001;
        end
    end

    // clock select taps
    always_comb begin
        cntTick = 1'b0;
        case (ctrlB_q[atc_pkg::CS_LSB +: 3]) // [R5]
            3'h0: cntTick = 1'b0;
            3'h1: cntTick = srcTick;
            3'h2: cntTick = srcTick & (&presc_q[2:0]);
            3'h3: cntTick = srcTick & (&presc_q[4:0]);
            3'h4: cntTick = srcTick & (&presc_q[5:0]);
            3'h5: cntTick = srcTick & (&presc_q[6:0]);
            3'h6: cntTick = srcTick & (&presc_q[7:0]);
            default: cntTick = srcTick & (&presc_q[9:0]);
        endcase
    end

    // match and overflow events, only on counting ticks
    assign match = cntTick & (cnt_q == ocr_q) & ~blockMatch_q; // [R7] [R6]
    assign bottomEv = cntTick & dirDown_q & (cnt_q == atc_pkg::CNT_BOTTOM);
    assign ovfEv = (wgm == atc_pkg::WGM_PHASE) ? bottomEv // [R20]
                   : (cntTick & (cnt_q == atc_pkg::CNT_MAX)); // [R20]

    // a counter write blocks the match on the following count
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            blockMatch_q <= 1'b0;
        end else if (asyncSel_q ? (xtalEdge & cntUb_q) : wrCnt) begin
            blockMatch_q <= 1'b1; // [R6]
        end else if (cntTick) begin
            blockMatch_q <= 1'b0; // [R6]
        end
    end

    // counter and direction per waveform mode
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cnt_q <= atc_pkg::RST_COUNT;
            dirDown_q <= 1'b0;
        end else if (asyncSel_q ? (xtalEdge & cntUb_q) : wrCnt) begin
            cnt_q <= asyncSel_q ? cntTmp_q : busReq.wrData; // [R6] [R22]
        end else if (cntTick) begin
            case (wgm) // [R21]
                atc_pkg::WGM_PHASE: begin
                    if (!dirDown_q && cnt_q == atc_pkg::CNT_MAX) begin
                        dirDown_q <= 1'b1;
                        cnt_q <= cnt_q - atc_pkg::CNT_ONE;
                    end else if (dirDown_q && cnt_q == atc_pkg::CNT_BOTTOM) begin
                        dirDown_q <= 1'b0;
                        cnt_q <= cnt_q + atc_pkg::CNT_ONE;
                    end else if (dirDown_q) begin
                        cnt_q <= cnt_q - atc_pkg::CNT_ONE;
                    end else begin
                        cnt_q <= cnt_q + atc_pkg::CNT_ONE;
                    end
                end
                default: begin
                    dirDown_q <= 1'b0;
                    // forced compares never reach this clear
                    if (cnt_q == top) begin
                        cnt_q <= atc_pkg::CNT_BOTTOM; // [R2]
                    end else begin
                        cnt_q <= cnt_q + atc_pkg::CNT_ONE;
                    end
                end
            endcase
        end
    end

    // compare output pin
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pin_q <= 1'b0;
        end else if (!isPwm) begin
            if (match || forceEv) begin // [R1] [R7]
                case (com)
                    atc_pkg::COM_TOGGLE: pin_q <= ~pin_q;
                    atc_pkg::COM_CLEAR: pin_q <= 1'b0;
                    atc_pkg::COM_SET: pin_q <= 1'b1;
                    default: pin_q <= pin_q;
                endcase
            end
        end else if (wgm == atc_pkg::WGM_FAST) begin
            if (match && com[1]) begin
                pin_q <= com[0];
            end else if (cntTick && cnt_q == atc_pkg::CNT_MAX && com[1]) begin
                pin_q <= ~com[0];
            end
        end else if (match && com[1]) begin
            pin_q <= com[0] ^ dirDown_q;
        end
    end

    // interrupt mask
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            mask_q <= atc_pkg::RST_MASK[1:0];
        end else if (wrMask) begin
            mask_q <= busReq.wrData[1:0];
        end
    end

    // flags: hardware set wins over vector or write-one clear
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            flags_q <= 2'b00;
        end else begin
            flags_q[atc_pkg::CMP_BIT] <= match | (flags_q[atc_pkg::CMP_BIT]
                & ~compareVectorAck
                & ~(wrFlags & busReq.wrData[atc_pkg::CMP_BIT])); // [R19] [R2]
            flags_q[atc_pkg::OVF_BIT] <= ovfEv | (flags_q[atc_pkg::OVF_BIT]
                & ~overflowVectorAck
                & ~(wrFlags & busReq.wrData[atc_pkg::OVF_BIT])); // [R20]
        end
    end

    // interrupt requests and crystal controls, registered
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cmpIrq_q <= 1'b0;
            ovfIrq_q <= 1'b0;
            oscEn_q <= 1'b0;
            extBuf_q <= 1'b0;
        end else begin
            cmpIrq_q <= flags_q[atc_pkg::CMP_BIT] & mask_q[atc_pkg::CMP_BIT]
                        & globalIrqEnable; // [R17]
            ovfIrq_q <= flags_q[atc_pkg::OVF_BIT] & mask_q[atc_pkg::OVF_BIT]
                        & globalIrqEnable; // [R18]
            oscEn_q <= ~extClk_q; // [R8]
            extBuf_q <= extClk_q & asyncSel_q; // [R8]
        end
    end

    // read data, valid the cycle after the read strobe
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdData_q <= 8'h00;
        end else if (busReq.rdStb) begin
            if (busReq.addr == atc_pkg::ADDR_CTRL_A) begin
                rdData_q <= {ctrlATmp_q[7:6], 4'h0, ctrlATmp_q[1:0]}; // [R15] [R16]
            end else if (busReq.addr == atc_pkg::ADDR_CTRL_B) begin
                rdData_q <= {5'h00, ctrlBTmp_q[2:0]}; // [R3] [R15] [R16]
            end else if (busReq.addr == atc_pkg::ADDR_COUNT) begin
                rdData_q <= cnt_q; // [R15]
            end else if (busReq.addr == atc_pkg::ADDR_COMPARE) begin
                rdData_q <= ocrTmp_q; // [R15]
            end else if (busReq.addr == atc_pkg::ADDR_ASYNC) begin
                rdData_q <= {1'b0, extClk_q, asyncSel_q, cntUb_q, ocrUb_q,
                             1'b0, ctlAUb_q, ctlBUb_q}; // [R16]
            end else if (busReq.addr == atc_pkg::ADDR_MASK) begin
                rdData_q <= {6'h00, mask_q}; // [R16]
            end else if (busReq.addr == atc_pkg::ADDR_FLAGS) begin
                rdData_q <= {6'h00, flags_q}; // [R16]
            end else begin
                rdData_q <= 8'h00;
            end
        end else begin
            rdData_q <= 8'h00;
        end
    end

    assign rdData = rdData_q;
    assign compareIrqReq = cmpIrq_q;
    assign overflowIrqReq = ovfIrq_q;
    assign compareOutputPin = pin_q;
    assign crystalOscEnable = oscEn_q;
    assign externalClockBufEnable = extBuf_q;
endmodule

// File: verification/atc_timer_properties.sv
// checker for the timer: read-back, interrupt gating and clock pin relations
// assumes it is bound to the timer top; one clock domain, arst_n as disable
`timescale 1ns/10ps
module atc_timer_properties (
    input wire logic clk,
    input wire logic arst_n,
    input wire atc_pkg::atc_req_s busReq,
    input wire logic [7:0] rdData,
    input wire logic crystalInputPin,
    input wire logic sysClkFromRc,
    input wire logic globalIrqEnable,
    input wire logic compareVectorAck,
    input wire logic overflowVectorAck,
    input wire logic compareIrqReq,
    input wire logic overflowIrqReq,
    input wire logic compareOutputPin,
    input wire logic crystalOscEnable,
    input wire logic externalClockBufEnable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // read data stands only in the cycle after a read strobe
    a_idle_read_zero: assert property (
        !$past(busReq.rdStb) |-> rdData == 8'h00)
        else $error("read data outside its cycle");
    // force strobe and reserved bits of control B read zero
    a_force_reads_zero: assert property (
        busReq.rdStb && busReq.addr == atc_pkg::ADDR_CTRL_B |=> rdData[7:3] == 5'h00)
        else $error("control B upper bits not zero");
    a_ctla_reserved_zero: assert property (
        busReq.rdStb && busReq.addr == atc_pkg::ADDR_CTRL_A |=> rdData[5:2] == 4'h0)
        else $error("control A reserved bits not zero");
    a_mask_flag_reserved: assert property (
        busReq.rdStb && (busReq.addr == atc_pkg::ADDR_MASK || busReq.addr == atc_pkg::ADDR_FLAGS)
        |=> rdData[7:2] == 6'h00)
        else $error("mask or flag reserved bits not zero");
    // async select written one without an rc system clock reads back zero
    a_async_forced_off: assert property (
        busReq.wrStb && busReq.addr == atc_pkg::ADDR_ASYNC && !sysClkFromRc
        ##2 busReq.rdStb && busReq.addr == atc_pkg::ADDR_ASYNC |=> !rdData[atc_pkg::ASEL_BIT])
        else $error("async select kept without rc clock");
    // no interrupt request while the global enable was low
    a_cmp_irq_gated: assert property (
        !$past(globalIrqEnable) |-> !compareIrqReq)
        else $error("compare request without global enable");
    a_ovf_irq_gated: assert property (
        !$past(globalIrqEnable) |-> !overflowIrqReq)
        else $error("overflow request without global enable");
    // oscillator and external buffer never both on
    a_clock_exclusive: assert property (
        !(crystalOscEnable && externalClockBufEnable))
        else $error("oscillator and external buffer both on");
endmodule

// File: verification/atc_timer_bench.sv
// self-checking bench for the 8-bit timer: readback, counting, flags, force, async
// assumes the design package is compiled first; the checker is bound at the foot
`timescale 1ns/10ps
module atc_timer_bench;
    typedef struct {
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } atc_row_s;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    atc_pkg::atc_req_s busReq = '0;
    logic crystalInputPin = 1'b0;
    logic sysClkFromRc = 1'b0;
    logic globalIrqEnable = 1'b0;
    logic compareVectorAck = 1'b0;
    logic overflowVectorAck = 1'b0;
    logic [7:0] rdData;
    logic compareIrqReq, overflowIrqReq, compareOutputPin;
    logic crystalOscEnable, externalClockBufEnable;
    logic [7:0] v;
    int nErrors = 0;
    int nTests = 0;
    int cycles = 0;
    int i;
    int div [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    logic [8:0] frc [4] = '{9'h181, 9'h100, 9'h081, 9'h084}; // control A, pin
    atc_row_s rows [11] = '{
        '{atc_pkg::ADDR_CTRL_A, 8'hFF, 8'hC3},
        '{atc_pkg::ADDR_CTRL_B, 8'h7F, 8'h07},
        '{atc_pkg::ADDR_CTRL_B, 8'h00, 8'h00},
        '{atc_pkg::ADDR_CTRL_A, 8'h00, 8'h00},
        '{atc_pkg::ADDR_COMPARE, 8'h5A, 8'h5A},
        '{atc_pkg::ADDR_COUNT, 8'h3C, 8'h3C},
        '{atc_pkg::ADDR_MASK, 8'hFF, 8'h03},
        '{atc_pkg::ADDR_ASYNC, 8'hFF, 8'h40},
        '{atc_pkg::ADDR_ASYNC, 8'h00, 8'h00},
        '{atc_pkg::ADDR_FLAGS, 8'hFF, 8'h00},
        '{3'h7, 8'hFF, 8'h00}};

    atc_timer atc_timer_inst (
        .clk(clk), .arst_n(arst_n), .busReq(busReq), .rdData(rdData),
        .crystalInputPin(crystalInputPin), .sysClkFromRc(sysClkFromRc),
        .globalIrqEnable(globalIrqEnable), .compareVectorAck(compareVectorAck),
        .overflowVectorAck(overflowVectorAck), .compareIrqReq(compareIrqReq),
        .overflowIrqReq(overflowIrqReq), .compareOutputPin(compareOutputPin),
        .crystalOscEnable(crystalOscEnable), .externalClockBufEnable(externalClockBufEnable));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            nErrors++;
            giveVerdict();
        end
    end

    task automatic giveVerdict();
        $display("tests %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            busReq <= '0;
        end
    endtask

    // one-cycle write strobe, released at the edge that takes it
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{a, d, 1'b1, 1'b0};
        idle(1);
    endtask

    // read data is sampled in the single cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        idle(1);
        @(negedge clk);
        d = rdData;
    endtask

    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] g;
        rd(a, g);
        chk(g, e);
    endtask

    task automatic waitHi(ref logic s);
        for (int n = 0; n < 40 && s !== 1'b1; n++) begin
            @(negedge clk);
        end
        chk({7'h00, s}, 8'h01);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        idle(3);
        // table of ordinary write and read-back cases
        for (i = 0; i < 11; i++) begin
            wr(rows[i].a, rows[i].d);
            rc(rows[i].a, rows[i].e);
        end
        $display("test readback done");
        // reset in mid-run clears every register
        @(posedge clk);
        arst_n <= 1'b0;
        idle(4);
        arst_n <= 1'b1;
        idle(3);
        for (i = 0; i < 7; i++) begin
            rc(3'(i), 8'h00);
        end
        chk({7'h00, crystalOscEnable}, 8'h01);
        $display("test reset done");
        // compare match raises flag and request; vector clears it
        wr(atc_pkg::ADDR_COMPARE, 8'h10);
        wr(atc_pkg::ADDR_COUNT, 8'h0E);
        wr(atc_pkg::ADDR_MASK, 8'h03);
        globalIrqEnable <= 1'b1;
        wr(atc_pkg::ADDR_CTRL_B, 8'h01);
        waitHi(compareIrqReq);
        wr(atc_pkg::ADDR_CTRL_B, 8'h00);
        rc(atc_pkg::ADDR_FLAGS, 8'h02);
        @(posedge clk);
        compareVectorAck <= 1'b1;
        idle(1);
        compareVectorAck <= 1'b0;
        rc(atc_pkg::ADDR_FLAGS, 8'h00);
        chk({7'h00, compareIrqReq}, 8'h00);
        // overflow past FF, cleared by writing one
        wr(atc_pkg::ADDR_COUNT, 8'hFD);
        wr(atc_pkg::ADDR_CTRL_B, 8'h01);
        waitHi(overflowIrqReq);
        wr(atc_pkg::ADDR_CTRL_B, 8'h00);
        rc(atc_pkg::ADDR_FLAGS, 8'h01);
        @(posedge clk);
        overflowVectorAck <= 1'b1;
        idle(1);
        overflowVectorAck <= 1'b0;
        rc(atc_pkg::ADDR_FLAGS, 8'h00);
        wr(atc_pkg::ADDR_COUNT, 8'hFF);
        wr(atc_pkg::ADDR_CTRL_B, 8'h01);
        wr(atc_pkg::ADDR_CTRL_B, 8'h00);
        rc(atc_pkg::ADDR_FLAGS, 8'h01);
        wr(atc_pkg::ADDR_FLAGS, 8'h01);
        rc(atc_pkg::ADDR_FLAGS, 8'h00);
        // counter write onto the compare value blocks the next match
        wr(atc_pkg::ADDR_COMPARE, 8'h20);
        wr(atc_pkg::ADDR_CTRL_B, 8'h01);
        wr(atc_pkg::ADDR_COUNT, 8'h20);
        idle(8);
        wr(atc_pkg::ADDR_CTRL_B, 8'h00);
        rc(atc_pkg::ADDR_FLAGS, 8'h00);
        $display("test flags done");
        // forced compare in set, clear and toggle output modes, counter stopped
        wr(atc_pkg::ADDR_COMPARE, 8'h33);
        wr(atc_pkg::ADDR_COUNT, 8'h33);
        for (i = 0; i < 4; i++) begin
            wr(atc_pkg::ADDR_CTRL_A, frc[i][8:1]);
            wr(atc_pkg::ADDR_CTRL_B, 8'h80);
            @(negedge clk);
            chk({7'h00, compareOutputPin}, {7'h00, frc[i][0]});
        end
        rc(atc_pkg::ADDR_COUNT, 8'h33);
        rc(atc_pkg::ADDR_FLAGS, 8'h00);
        rc(atc_pkg::ADDR_CTRL_B, 8'h00);
        wr(atc_pkg::ADDR_CTRL_A, 8'h00);
        $display("test force done");
        // clock selects 1 to 7 each run about three periods of their divider
        for (i = 1; i < 8; i++) begin
            wr(atc_pkg::ADDR_COUNT, 8'h00);
            wr(atc_pkg::ADDR_CTRL_B, 8'(i));
            idle(3 * div[i] - 3);
            wr(atc_pkg::ADDR_CTRL_B, 8'h00);
            rd(atc_pkg::ADDR_COUNT, v);
            nTests++;
            if (v < 8'h02 || v > 8'h04) begin
                nErrors++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, v, 8'h03);
            end
        end
        $display("test prescaler done");
        // async mode on the external clock: busy flag until the pin rises
        @(posedge clk);
        sysClkFromRc <= 1'b1;
        wr(atc_pkg::ADDR_ASYNC, 8'h40);
        wr(atc_pkg::ADDR_ASYNC, 8'h60);
        rc(atc_pkg::ADDR_ASYNC, 8'h60);
        chk({6'h00, crystalOscEnable, externalClockBufEnable}, 8'h01);
        wr(atc_pkg::ADDR_COMPARE, 8'h77);
        rc(atc_pkg::ADDR_ASYNC, 8'h68);
        rc(atc_pkg::ADDR_COMPARE, 8'h77);
        @(posedge clk);
        crystalInputPin <= 1'b1;
        idle(6);
        crystalInputPin <= 1'b0;
        rc(atc_pkg::ADDR_ASYNC, 8'h60);
        $display("test async done");
        giveVerdict();
    end
endmodule

bind atc_timer atc_timer_properties atc_timer_properties_inst (
    .clk(clk), .arst_n(arst_n), .busReq(busReq), .rdData(rdData),
    .crystalInputPin(crystalInputPin), .sysClkFromRc(sysClkFromRc),
    .globalIrqEnable(globalIrqEnable), .compareVectorAck(compareVectorAck),
    .overflowVectorAck(overflowVectorAck), .compareIrqReq(compareIrqReq),
    .overflowIrqReq(overflowIrqReq), .compareOutputPin(compareOutputPin),
    .crystalOscEnable(crystalOscEnable), .externalClockBufEnable(externalClockBufEnable));
